// >>> design/ssf_sample_fifo.sv
// Sample FIFO with overflow policy, flags, delay counter and mode indicator.
// Functional notes
// - Thirty-two five-byte samples, byte-wide read port.
// - Enabled FIFO is read at pressure high address.
// - Four following data addresses read zero.
// - Acquisition continues during FIFO reads.
// - Bytes come oldest first; empty reads zero.
// - Count drops by one per consumed sample.
// - Watermark only flags, never stops writes.
// - Writes follow the selected acquisition rate.
// - Policy: disabled, circular, stop-when-full, unused.
// - Flush on disable and standby-to-active.
// - Disabling clears flags and count.
// - Overflow flag set at count thirty-two.
// - Watermark flag when count equals level.
// - Zero level disables watermark flag.
// - Direct circular/stop switch is refused.
// - Policy writable while active.
// - Policy and level writable in standby.
// - Delay counter counts ticks from first overflow.
// - Delay runs after overflow, clears on drain.
// - Mode indicator bit zero, upper bits zero.
// - Count reads zero to thirty-two.
// - Flags are levels; status read pulses out.
module ssf_sample_fifo (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic acq_tick, // Sample-time tick from another domain.
  input wire ssf_pkg::ssf_sample_t sample_in, // Latest conversion result.
  input wire logic active_mode, // High in active operation.
  input wire logic [3:0] acquisition_rate_select, // Rate field of second_control_register.
  input wire ssf_pkg::ssf_reg_req_t reg_req, // Register read or write strobe.
  output logic [7:0] reg_rdata_r, // Read answer, one cycle after the strobe.
  output logic reg_rvalid_r, // Marks the read answer.
  output logic status_read_r // Pulse: status register was read.
);
  import ssf_pkg::*;
  // ==========================================================================
  // Tick synchroniser
  // ==========================================================================
  logic tick_s1_r, tick_s2_r, tick_s3_r, tick_lvl_r; // Stages and settled level.
  logic tick_edge; // One cycle per settled rising edge.
  // Three stages; only the second and third are compared.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      tick_s1_r <= 1'b0;
      tick_s2_r <= 1'b0;
      tick_s3_r <= 1'b0;
      tick_lvl_r <= 1'b0;
    end
    else
    begin
      tick_s1_r <= acq_tick;
      tick_s2_r <= tick_s1_r;
      tick_s3_r <= tick_s2_r;
      if (tick_s2_r == tick_s3_r)
      begin
        tick_lvl_r <= tick_s3_r;
      end
    end
  end
  assign tick_edge = (tick_s2_r == tick_s3_r) && tick_s3_r && !tick_lvl_r;
  // ==========================================================================
  // FIFO state
  // ==========================================================================
  ssf_sample_t mem [FIFO_DEPTH]; // Sample storage, no reset needed.
  logic [4:0] wr_ptr_r, wr_ptr_nxt; // Next slot to fill.
  logic [4:0] rd_ptr_r, rd_ptr_nxt; // Oldest sample.
  logic [5:0] count_r, count_nxt; // stored_sample_count.
  logic [2:0] byte_idx_r, byte_idx_nxt; // Byte within the oldest sample.
  logic [1:0] policy_r, policy_nxt; // Overflow policy field.
  logic [5:0] watermark_level_r, watermark_level_nxt; // Watermark level field.
  logic overflow_flag_r, overflow_flag_nxt; // Level flag.
  logic watermark_hit_flag_r, watermark_hit_flag_nxt; // Level flag.
  logic [7:0] delay_r, delay_nxt; // ticks_since_last_write.
  logic delay_run_r, delay_run_nxt; // Set by overflow or wrap.
  logic active_r, active_nxt; // operating_mode_indicator bit.
  logic [15:0] div_r, div_nxt; // Acquisition rate divider.
  logic [7:0] rdata_nxt; // Next read answer.
  logic mem_we; // Store sample_in this cycle.
  logic fifo_rd; // Read strobe on the aliased port.
  logic pop; // Oldest sample fully consumed.
  logic [5:0] cnt_after; // Count after any pop.
  logic write_now; // A sample is due this cycle.
  logic flush; // Drop all contents.
  logic [1:0] new_policy; // Policy field of a setup write.
  ssf_sample_t front; // Oldest sample.
  // Picks one byte of a sample (oldest stored or latest result), pressure high first.
  function automatic logic [7:0] pick_byte(input ssf_sample_t s, input logic [2:0] i);
    logic [7:0] b;
    b = s.t_lo;
    unique case (i)
      3'h0: b = s.p_hi;
      3'h1: b = s.p_mid;
      3'h2: b = s.p_lo;
      3'h3: b = s.t_hi;
      default: b = s.t_lo;
    endcase
    return b;
  endfunction
  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  // Reads, writes, acquisition and flags are resolved in one place so that a
  // pop and a new sample in the same cycle never fight over the count.
  always_comb
  begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    byte_idx_nxt = byte_idx_r;
    policy_nxt = policy_r;
    watermark_level_nxt = watermark_level_r;
    delay_nxt = delay_r;
    delay_run_nxt = delay_run_r;
    active_nxt = active_mode;
    div_nxt = div_r;
    mem_we = 1'b0;
    pop = 1'b0;
    rdata_nxt = 8'h00;
    front = mem[rd_ptr_r];
    new_policy = reg_req.wdata[POLICY_MSB:POLICY_LSB];
    fifo_rd = reg_req.rd && (reg_req.addr == ADDR_OUT_P_HI) && (policy_r != POLICY_DISABLED);
    // The divider keeps counting during reads, so acquisition never pauses.
    write_now = 1'b0;
    if (tick_edge && active_r)
    begin
      if (div_r >= ((DIV_ONE << acquisition_rate_select) - DIV_ONE))
      begin
        div_nxt = 16'h0000;
        write_now = (policy_r != POLICY_DISABLED);
      end
      else
      begin
        div_nxt = div_r + DIV_ONE;
      end
    end
    // Register reads; data addresses alias onto the FIFO while enabled.
    unique case (reg_req.addr)
      ADDR_OUT_P_HI: rdata_nxt = (policy_r != POLICY_DISABLED) ? 8'h00 : sample_in.p_hi;
      ADDR_FIFO_STATUS: rdata_nxt = {overflow_flag_r, watermark_hit_flag_r, count_r};
      ADDR_FIFO_SETUP: rdata_nxt = {policy_r, watermark_level_r};
      ADDR_TICKS_SINCE_WRITE: rdata_nxt = delay_r;
      ADDR_OP_MODE_IND: rdata_nxt = {7'h00, active_r};
      default: rdata_nxt = 8'h00;
    endcase
    if (reg_req.addr >= ADDR_OUT_P_MID && reg_req.addr <= ADDR_OUT_T_LO && policy_r == POLICY_DISABLED)
    begin
      rdata_nxt = pick_byte(sample_in, 3'(reg_req.addr - ADDR_OUT_P_HI));
    end
    // An enabled FIFO answers zeros on the four following addresses.
    if (fifo_rd && count_r != 6'h00)
    begin
      rdata_nxt = pick_byte(front, byte_idx_r);
      if (byte_idx_r == LAST_BYTE_IDX)
      begin
        byte_idx_nxt = 3'h0;
        pop = 1'b1;
        rd_ptr_nxt = rd_ptr_r + 5'h01;
      end
      else
      begin
        byte_idx_nxt = byte_idx_r + 3'h1;
      end
    end
    cnt_after = count_r - {5'h00, pop};
    count_nxt = cnt_after;
    // Writing past the watermark is allowed; only the flag follows it.
    if (write_now && tick_edge)
    begin
      if (cnt_after == COUNT_FULL)
      begin
        delay_run_nxt = 1'b1;
        if (policy_r == POLICY_CIRCULAR)
        begin
          mem_we = 1'b1;
          wr_ptr_nxt = wr_ptr_r + 5'h01;
          rd_ptr_nxt = rd_ptr_nxt + 5'h01;
          byte_idx_nxt = 3'h0; // A half-read oldest sample is gone.
        end
      end
      else
      begin
        mem_we = 1'b1;
        wr_ptr_nxt = wr_ptr_r + 5'h01;
        count_nxt = cnt_after + 6'h01;
      end
    end
    // Delay counter advances per sample tick once overflow or wrap began.
    if (tick_edge && delay_run_r && delay_r != DELAY_MAX)
    begin
      delay_nxt = delay_r + 8'h01;
    end
    if (pop && count_nxt == 6'h00)
    begin
      delay_nxt = 8'h00;
      delay_run_nxt = 1'b0;
    end
    // Setup write: policy any time, watermark only in standby.
    if (reg_req.wr && reg_req.addr == ADDR_FIFO_SETUP)
    begin
      if (new_policy != POLICY_UNUSED &&
          !(policy_r != POLICY_DISABLED && new_policy != POLICY_DISABLED && new_policy != policy_r))
      begin
        policy_nxt = new_policy;
      end
      if (!active_r)
      begin
        watermark_level_nxt = reg_req.wdata[WMRK_MSB:0];
      end
    end
    flush = (policy_nxt == POLICY_DISABLED) || (active_mode && !active_r);
    if (flush)
    begin
      wr_ptr_nxt = 5'h00;
      rd_ptr_nxt = 5'h00;
      byte_idx_nxt = 3'h0;
      count_nxt = 6'h00;
      delay_nxt = 8'h00;
      delay_run_nxt = 1'b0;
      mem_we = 1'b0;
    end
    overflow_flag_nxt = (count_nxt == COUNT_FULL);
    watermark_hit_flag_nxt = (watermark_level_nxt != 6'h00) && (count_nxt == watermark_level_nxt);
  end
  // ==========================================================================
  // State registers
  // ==========================================================================
  // Only registers the next values; sample storage has no reset.
  always_ff @(posedge core_clk)
  begin
    if (mem_we)
    begin
      mem[wr_ptr_r] <= sample_in;
    end
    if (rst)
    begin
      wr_ptr_r <= 5'h00;
      rd_ptr_r <= 5'h00;
      count_r <= 6'h00;
      byte_idx_r <= 3'h0;
      {policy_r, watermark_level_r} <= SETUP_RESET;
      overflow_flag_r <= 1'b0;
      watermark_hit_flag_r <= 1'b0;
      delay_r <= 8'h00;
      delay_run_r <= 1'b0;
      active_r <= 1'b0;
      div_r <= 16'h0000;
      reg_rdata_r <= 8'h00;
      reg_rvalid_r <= 1'b0;
      status_read_r <= 1'b0;
    end
    else
    begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
      byte_idx_r <= byte_idx_nxt;
      policy_r <= policy_nxt;
      watermark_level_r <= watermark_level_nxt;
      overflow_flag_r <= overflow_flag_nxt;
      watermark_hit_flag_r <= watermark_hit_flag_nxt;
      delay_r <= delay_nxt;
      delay_run_r <= delay_run_nxt;
      active_r <= active_nxt;
      div_r <= div_nxt;
      reg_rdata_r <= reg_req.rd ? rdata_nxt : 8'h00;
      reg_rvalid_r <= reg_req.rd;
      status_read_r <= reg_req.rd && (reg_req.addr == ADDR_FIFO_STATUS);
    end
  end
  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_count_bound: assert property (count_r <= COUNT_FULL) else $error("count above 32");
  a_ovf_at_full: assert property (overflow_flag_r == (count_r == COUNT_FULL)) else $error("overflow flag wrong");
  a_wm_zero_off: assert property (watermark_level_r == 6'h00 |-> !watermark_hit_flag_r)
    else $error("watermark flag with zero level");
  a_wm_equal: assert property (watermark_level_r != 6'h00 && count_r == watermark_level_r |-> watermark_hit_flag_r)
    else $error("watermark flag missing");
  a_disable_clears: assert property (policy_r == POLICY_DISABLED |-> count_r == 6'h00 && !overflow_flag_r)
    else $error("disabled fifo not cleared");
  a_alias_zero: assert property (reg_req.rd && policy_r != POLICY_DISABLED && reg_req.addr inside {[8'h02:8'h05]}
    |=> reg_rdata_r == 8'h00) else $error("aliased address not zero");
  a_empty_read_zero: assert property (fifo_rd && count_r == 6'h00 |=> reg_rdata_r == 8'h00)
    else $error("empty fifo read not zero");
  a_no_direct_switch: assert property (policy_r != POLICY_DISABLED |=> policy_r == $past(policy_r) ||
    policy_r == POLICY_DISABLED) else $error("direct policy switch");
  a_pop_count: assert property (pop && !mem_we && !flush |=> count_r == $past(count_r) - 6'h01)
    else $error("count not decremented");
  a_mode_bits: assert property (reg_req.rd && reg_req.addr == ADDR_OP_MODE_IND |=> reg_rdata_r[7:1] == 7'h00)
    else $error("mode upper bits set");
  c_fill_full: cover property (count_r == COUNT_FULL);
  c_wrap: cover property (policy_r == POLICY_CIRCULAR && count_r == COUNT_FULL ##1 mem_we);
  c_drain: cover property (pop ##1 count_r == 6'h00);
  c_wm_hit: cover property (watermark_hit_flag_r);
endmodule // ssf_sample_fifo

// >>> shared/ssf_pkg.sv
// Package with register map, field layout, reset values and sample types for the sample FIFO.
package ssf_pkg;
  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [7:0] ADDR_OUT_P_HI = 8'h01; // Aliased FIFO read port while enabled.
  localparam logic [7:0] ADDR_OUT_P_MID = 8'h02; // First of the four zeroed data addresses.
  localparam logic [7:0] ADDR_OUT_T_LO = 8'h05; // Last of the zeroed data addresses.
  localparam logic [7:0] ADDR_FIFO_STATUS = 8'h0d; // Flags and stored sample count.
  localparam logic [7:0] ADDR_FIFO_READ_PORT = 8'h0e; // Not decoded; reads zero, the FIFO is read at ADDR_OUT_P_HI.
  localparam logic [7:0] ADDR_FIFO_SETUP = 8'h0f; // Policy and watermark level.
  localparam logic [7:0] ADDR_TICKS_SINCE_WRITE = 8'h10; // Delay counter.
  localparam logic [7:0] ADDR_OP_MODE_IND = 8'h11; // Standby or active indicator.
  // ==========================================================================
  // Field layout and encodings
  // ==========================================================================
  localparam int POLICY_MSB = 7; // Overflow policy field, upper bit.
  localparam int POLICY_LSB = 6; // Overflow policy field, lower bit.
  localparam int WMRK_MSB = 5; // Watermark level field, upper bit.
  localparam logic [1:0] POLICY_DISABLED = 2'h0; // FIFO off.
  localparam logic [1:0] POLICY_CIRCULAR = 2'h1; // Oldest sample replaced when full.
  localparam logic [1:0] POLICY_STOP = 2'h2; // New samples dropped when full.
  localparam logic [1:0] POLICY_UNUSED = 2'h3; // Not a legal policy.
  // ==========================================================================
  // Sizes and reset values
  // ==========================================================================
  localparam int FIFO_DEPTH = 32; // Samples held.
  localparam logic [5:0] COUNT_FULL = 6'h20; // Count that means full.
  localparam logic [2:0] LAST_BYTE_IDX = 3'h4; // Fifth byte of a sample.
  localparam logic [7:0] SETUP_RESET = 8'h00; // Policy and watermark after reset.
  localparam logic [7:0] DELAY_MAX = 8'hff; // Delay counter saturates here.
  localparam logic [15:0] DIV_ONE = 16'h0001; // Base of the rate divider.
  // One stored sample: pressure high, middle, low, temperature high, low.
  typedef struct packed {
    logic [7:0] p_hi;
    logic [7:0] p_mid;
    logic [7:0] p_lo;
    logic [7:0] t_hi;
    logic [7:0] t_lo;
  } ssf_sample_t;
  // Register access strobes from the device's serial front end.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ssf_reg_req_t;
endpackage

// >>> bench/ssf_acq_model.sv
// Acquisition source model: sample-time ticks and conversion results.
module ssf_acq_model (
  output logic acq_tick,
  output ssf_pkg::ssf_sample_t sample_out,
  output logic [7:0] made
);
  timeunit 1ns;
  timeprecision 1ps;
  import ssf_pkg::*;
  // ==========================================================================
  // Sample pattern and tick bursts
  // ==========================================================================
  // Byte j of sample k; the top bits carry the byte position so a swap shows.
  function automatic logic [7:0] pat(input logic [7:0] k, input int j);
    pat = k ^ {j[2:0], 5'h00};
  endfunction
  // The tick stands low until a burst is asked for.
  initial
  begin
    acq_tick = 1'b0;
    made = 8'h00;
    sample_out = '0;
  end
  // Emits n ticks of 200 ns; the result changes with the rising tick and is held a
  // whole period, so the late synchronised capture still sees a settled value.
  task automatic emit(input int n);
    #7;
    repeat (n)
    begin
      made = made + 8'h01;
      sample_out = '{pat(made, 0), pat(made, 1), pat(made, 2), pat(made, 3), pat(made, 4)};
      acq_tick = 1'b1;
      #100;
      acq_tick = 1'b0;
      #100;
    end
  endtask
endmodule // ssf_acq_model

// >>> bench/tb_top.sv
// Testbench for the sample FIFO: register calls with expected values.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ssf_pkg::*;
  // ==========================================================================
  // Signals and instances
  // ==========================================================================
  logic core_clk; // 40 MHz core clock.
  logic rst; // Synchronous reset, active high.
  logic active_mode; // Standby or active operation.
  logic [3:0] rate_sel; // Writes every 2^N ticks.
  ssf_reg_req_t req; // Register strobe bundle.
  logic [7:0] rdata; // Read answer.
  logic rvalid; // Marks the read answer.
  logic acq_tick; // Tick from the source model.
  ssf_sample_t sample; // Result from the source model.
  logic [7:0] made; // Samples emitted so far.
  logic [7:0] v; // Last value read.
  logic [7:0] base; // Sample index before a burst.
  logic stat_rd; // Pulse that marks a status register read.
  logic [1:0] flags; // Answer marker and status pulse seen after the last access.
  int err_total;
  int num_checks;
  ssf_acq_model ssf_acq_model_i (.acq_tick(acq_tick), .sample_out(sample), .made(made));
  ssf_sample_fifo ssf_sample_fifo_i (.core_clk(core_clk), .rst(rst), .acq_tick(acq_tick), .sample_in(sample),
    .active_mode(active_mode), .acquisition_rate_select(rate_sel), .reg_req(req), .reg_rdata_r(rdata),
    .reg_rvalid_r(rvalid), .status_read_r(stat_rd));
  // Free-running clock.
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // ==========================================================================
  // Tasks
  // ==========================================================================
  // Counts every compare and reports a mismatch at once.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // One access: strobe for one edge, answer taken just after that edge.
  // Starting on a fresh edge keeps the strobe from being set twice in one step.
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    req = '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge core_clk);
    #1;
    req = '0;
    v = rdata;
    flags = {rvalid, stat_rd};
  endtask
  // A write has no answer, so neither marker may pulse after it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    access(1'b1, a, d);
    check({6'h00, flags}, 8'h00);
  endtask
  // A read must be marked, and only a status read may pulse the status line.
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    access(1'b0, a, 8'h00);
    check(v, exp);
    check({6'h00, flags}, {6'h00, 1'b1, a == ADDR_FIFO_STATUS});
  endtask
  // Pops one whole sample at the aliased port and compares its five bytes.
  task automatic pop(input logic [7:0] k);
    for (int j = 0; j < 5; j++)
    begin
      access(1'b0, ADDR_OUT_P_HI, 8'h00);
      check(v, ssf_acq_model_i.pat(k, j));
    end
  endtask
  // Changes the operating mode and lets the indicator settle.
  task automatic set_mode(input logic m);
    @(posedge core_clk);
    #1;
    active_mode = m;
    repeat (2) @(posedge core_clk);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Watchdog: the tests need about 1200 cycles.
  initial
  begin
    repeat (8000) @(posedge core_clk);
    err_total++;
    close_out();
  end
  // ==========================================================================
  // Test sequence
  // ==========================================================================
  initial
  begin
    rst = 1'b1;
    active_mode = 1'b0;
    rate_sel = 4'h0;
    req = '0;
    err_total = 0;
    num_checks = 0;
    repeat (8) @(posedge core_clk);
    #1;
    rst = 1'b0;
    rchk(ADDR_FIFO_SETUP, SETUP_RESET);
    rchk(ADDR_OP_MODE_IND, 8'h00);
    rchk(ADDR_FIFO_STATUS, 8'h00);
    wr(ADDR_OP_MODE_IND, 8'hff);
    rchk(ADDR_OP_MODE_IND, 8'h00);
    $display("test reset done");
    // Fill to the watermark, then read while ticks keep arriving.
    wr(ADDR_FIFO_SETUP, 8'h43);
    rchk(ADDR_FIFO_SETUP, 8'h43);
    set_mode(1'b1);
    rchk(ADDR_OP_MODE_IND, 8'h01);
    ssf_acq_model_i.emit(3);
    rchk(ADDR_FIFO_STATUS, 8'h43);
    for (int a = 2; a < 6; a++)
      rchk(8'(a), 8'h00);
    fork
      ssf_acq_model_i.emit(4);
      begin
        pop(8'h01);
        pop(8'h02);
      end
    join
    rchk(ADDR_FIFO_STATUS, 8'h05);
    for (int k = 3; k < 8; k++)
      pop(8'(k));
    rchk(ADDR_OUT_P_HI, 8'h00);
    rchk(ADDR_FIFO_STATUS, 8'h00);
    $display("test watermark done");
    // Circular policy: overflow, refused direct switch, full drain.
    wr(ADDR_FIFO_SETUP, 8'h00);
    wr(ADDR_FIFO_SETUP, 8'h40);
    base = made;
    ssf_acq_model_i.emit(35);
    rchk(ADDR_FIFO_STATUS, 8'ha0);
    access(1'b0, ADDR_TICKS_SINCE_WRITE, 8'h00);
    check(8'(v != 8'h00), 8'h01);
    wr(ADDR_FIFO_SETUP, 8'h80);
    rchk(ADDR_FIFO_SETUP, 8'h43);
    for (int k = 4; k < 36; k++)
      pop(8'(base + k));
    rchk(ADDR_TICKS_SINCE_WRITE, 8'h00);
    $display("test circular done");
    // Stop policy: the oldest sample survives, later ones are dropped.
    wr(ADDR_FIFO_SETUP, 8'h00);
    rchk(ADDR_FIFO_STATUS, 8'h00);
    wr(ADDR_FIFO_SETUP, 8'h80);
    rchk(ADDR_FIFO_SETUP, 8'h83);
    base = made;
    ssf_acq_model_i.emit(34);
    rchk(ADDR_FIFO_STATUS, 8'ha0);
    access(1'b0, ADDR_TICKS_SINCE_WRITE, 8'h00);
    check(8'(v != 8'h00), 8'h01);
    pop(8'(base + 1));
    wr(ADDR_FIFO_SETUP, 8'h00);
    wr(ADDR_FIFO_SETUP, 8'hc0);
    rchk(ADDR_FIFO_SETUP, 8'h03);
    // With the FIFO disabled the data addresses show the latest result again.
    rchk(ADDR_OUT_P_HI, ssf_acq_model_i.pat(made, 0));
    rchk(ADDR_OUT_P_MID, ssf_acq_model_i.pat(made, 1));
    $display("test stop done");
    // Flush on entering active operation, zero level, slower rate.
    wr(ADDR_FIFO_SETUP, 8'h40);
    ssf_acq_model_i.emit(2);
    rchk(ADDR_FIFO_STATUS, 8'h02);
    set_mode(1'b0);
    rchk(ADDR_OP_MODE_IND, 8'h00);
    wr(ADDR_FIFO_SETUP, 8'h40);
    rchk(ADDR_FIFO_SETUP, 8'h40);
    set_mode(1'b1);
    rchk(ADDR_FIFO_STATUS, 8'h00);
    rate_sel = 4'h1;
    ssf_acq_model_i.emit(4);
    rchk(ADDR_FIFO_STATUS, 8'h02);
    $display("test flush done");
    close_out();
  end
endmodule // tb_top
